/* File: src/host_slot_poll_arbiter.sv */
// polling arbiter that shares one drive controller among eight host slots
//
// Function
// - configuration record is eight slot-type bytes then four poll bytes, twelve total.
// - slot type 0 empty, 1 cascaded mux, 2 minicomputer, 128 computer host.
// - without stored settings every slot type reads as cascaded multiplexer.
// - poll byte one scales total dwell time at a slot; default 180.
// - poll byte two scales the wait for a first request; default 16.
// - poll byte three caps transactions per visit; default 32.
// - poll byte four has no effect and defaults to zero.
// - table governs only on a master multiplexer with selector set right.
// - a host whose slot is wrongly described cannot reach the drive.
// - record changes only by reading, editing and rewriting the whole block.
`timescale 1ns/1ps
module host_slot_poll_arbiter
    import slot_poll_pkg::*;
(
    input  wire logic                 clk,              // system clock, 20 MHz
    input  wire logic                 sys_rst,          // synchronous reset, active high
    input  wire wb_req_t              wb_req,           // wishbone request from the master
    output wb_rsp_t                   wb_rsp,           // wishbone ack and read data
    input  wire logic [NUM_SLOTS-1:0] slot_req_pin,     // request level from each slot, async
    input  wire logic                 master_mux_pin,   // high when this is the master mux, async
    input  wire logic                 switch_right_pin, // selector in the right position, async
    input  wire logic                 txn_done,         // drive finished one transaction, pulse
    output logic      [NUM_SLOTS-1:0] slot_grant,       // one-hot slot now connected to drive
    output kind_t                     slot_kind,        // decoded type of the granted slot
    output logic                      arb_active        // table-driven polling enabled
);

    arb_regs_t st_q;
    arb_regs_t st_d;

    logic [SYNC_W-1:0]    pins_s;
    logic [NUM_SLOTS-1:0] req_s;
    logic                 mode_ok;
    logic                 tick;

    pin_sync u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin_in  ({switch_right_pin, master_mux_pin, slot_req_pin}),
        .level   (pins_s)
    );

    poll_tick u_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick)
    );

    assign req_s   = pins_s[NUM_SLOTS-1:0];
    assign mode_ok = pins_s[NUM_SLOTS] & pins_s[NUM_SLOTS+1];

    // a slot is pollable only when its byte decodes to a known attached type
    function automatic logic [NUM_SLOTS-1:0] usable_slots(input logic [CFG_BYTES-1:0][7:0] rec);
        kind_t k;
        usable_slots = '0;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            k = decode_kind(rec[i]);
            usable_slots[i] = (k != KIND_EMPTY) && (k != KIND_INVALID);
        end
    endfunction

    // next usable slot after cur in ascending order with wrap; msb flags a hit
    function automatic logic [3:0] next_slot(input logic [NUM_SLOTS-1:0] ok, input logic [2:0] cur);
        logic [2:0] idx;
        logic       hit;
        hit = 1'b0;
        next_slot = '0;
        for (int k = 1; k <= NUM_SLOTS; k++) begin
            idx = 3'(cur + 3'(k));
            if (!hit && ok[idx]) begin
                hit       = 1'b1;
                next_slot = {1'b1, idx};
            end
        end
    endfunction

    // register read view; unmapped words read zero
    function automatic logic [31:0] read_word(input arb_regs_t r, input logic [7:0] adr);
        read_word = '0;
        if (adr < REG_CTRL) begin
            read_word[7:0] = r.shadow[adr[5:2]];
        end else if (adr == REG_STATUS) begin
            read_word[ST_SLOT_LSB +: 3] = r.slot;
            read_word[ST_ENABLED]       = r.enabled;
            read_word[ST_GRANTED]       = |r.grant;
            read_word[ST_SERVING]       = (r.state == ARB_SERVE);
            read_word[ST_TXN_LSB +: 8]  = r.txns;
            read_word[ST_TICK_LSB +: 8] = r.ticks;
        end
    endfunction

    logic [NUM_SLOTS-1:0] ok_mask;
    logic [3:0]           pick;
    logic                 bus_hit;
    logic                 bus_wr;
    logic [7:0]           txn_next;

    always_comb begin
        st_d     = st_q;
        ok_mask  = usable_slots(st_q.record);
        pick     = next_slot(ok_mask, st_q.slot);
        bus_hit  = wb_req.cyc & wb_req.stb & ~st_q.rsp.ack;
        bus_wr   = bus_hit & wb_req.we & wb_req.sel[0];
        txn_next = st_q.txns;

        // classic wishbone: answer one cycle after the strobe, drop ack the next
        st_d.rsp.ack = bus_hit;
        if (bus_hit) begin
            st_d.rsp.dat = read_word(st_q, wb_req.adr);
        end

        // edits land in the shadow copy; the live record changes only on commit
        if (bus_wr && wb_req.adr < REG_CTRL) begin
            st_d.shadow[wb_req.adr[5:2]] = wb_req.dat[7:0];
        end
        if (bus_wr && wb_req.adr == REG_CTRL && wb_req.dat[CTRL_COMMIT]) begin
            st_d.record = st_q.shadow;
        end

        st_d.enabled = mode_ok;

        // one counter from arrival at a slot covers both the first-request wait and the dwell
        if (tick && st_q.ticks != 8'hff) begin
            st_d.ticks = st_q.ticks + 8'h01;
        end

        case (st_q.state)
            ARB_IDLE: begin
                st_d.grant = '0;
                if (mode_ok) begin
                    st_d.state = ARB_SEEK;
                end
            end
            ARB_SEEK: begin
                st_d.grant = '0;
                if (pick[3]) begin
                    st_d.slot  = pick[2:0];
                    st_d.ticks = '0;
                    st_d.txns  = '0;
                    st_d.grant = NUM_SLOTS'(1) << pick[2:0];
                    st_d.kind  = decode_kind(st_q.record[pick[2:0]]);
                    st_d.state = ARB_WAIT;
                end
            end
            ARB_WAIT: begin
                if (!ok_mask[st_q.slot]) begin
                    st_d.grant = '0;
                    st_d.state = ARB_SEEK;
                end else if (req_s[st_q.slot]) begin
                    st_d.state = ARB_SERVE;
                end else if (st_q.ticks >= st_q.record[POLL_FIRST]) begin
                    st_d.grant = '0;
                    st_d.state = ARB_SEEK;
                end
            end
            ARB_SERVE: begin
                if (txn_done && st_q.txns != 8'hff) begin
                    txn_next = st_q.txns + 8'h01;
                end
                st_d.txns = txn_next;
                if (!ok_mask[st_q.slot]) begin
                    st_d.grant = '0;
                    st_d.state = ARB_SEEK;
                end else if (st_q.ticks >= st_q.record[POLL_DWELL]) begin
                    // the dwell cap holds however busy the host is, so no slot can hog the drive
                    st_d.grant = '0;
                    st_d.state = ARB_SEEK;
                end else if (txn_next >= st_q.record[POLL_TXN_CAP]) begin
                    st_d.grant = '0;
                    st_d.state = ARB_SEEK;
                end
            end
            default: begin
                st_d.grant = '0;
                st_d.state = ARB_IDLE;
            end
        endcase

        // outside the master-and-right-selector mode the table steers nothing and no slot is granted
        if (!mode_ok) begin
            st_d.grant = '0;
            st_d.state = ARB_IDLE;
        end
    end

    // poll byte four is stored and read back but never consulted
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q        <= '0;
            st_q.shadow <= CFG_DEFAULT;
            st_q.record <= CFG_DEFAULT;
            st_q.slot   <= 3'h7;
            st_q.state  <= ARB_IDLE;
            st_q.kind   <= KIND_EMPTY;
        end else begin
            st_q <= st_d;
        end
    end

    assign wb_rsp     = st_q.rsp;
    assign slot_grant = st_q.grant;
    assign slot_kind  = st_q.kind;
    assign arb_active = st_q.enabled;

endmodule // host_slot_poll_arbiter

/* File: src/pin_sync.sv */
// three-stage synchroniser for asynchronous pins, output moves when stages two and three agree
`timescale 1ns/1ps
module pin_sync
    import slot_poll_pkg::*;
(
    input  wire logic              clk,     // system clock
    input  wire logic              sys_rst, // synchronous reset, active high
    input  wire logic [SYNC_W-1:0] pin_in,  // raw asynchronous levels
    output logic      [SYNC_W-1:0] level    // filtered level
);

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] out;
    } sync_regs_t;

    sync_regs_t st_q;
    sync_regs_t st_d;

    always_comb begin
        st_d     = st_q;
        st_d.s1  = pin_in;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        // a bit changes only once the two later stages agree on it
        st_d.out = (st_q.s2 & st_q.s3) | (st_q.out & (st_q.s2 | st_q.s3));
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.out;

endmodule // pin_sync

/* File: src/poll_tick.sv */
// divider giving a one-cycle tick enable that times the dwell and first-request limits
`timescale 1ns/1ps
module poll_tick
    import slot_poll_pkg::*;
(
    input  wire logic clk,     // system clock
    input  wire logic sys_rst, // synchronous reset, active high
    output logic      tick     // one-cycle pulse every tick period
);

    localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);

    typedef struct packed {
        logic [TICK_CNT_W-1:0] cnt;
        logic                  tick;
    } tick_regs_t;

    tick_regs_t st_q;
    tick_regs_t st_d;

    always_comb begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt == TICK_LAST) begin
            st_d.cnt  = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

endmodule // poll_tick

/* File: src/slot_poll_pkg.sv */
// shared constants, types and decode helpers for the slot polling arbiter
package slot_poll_pkg;

    // clock and polling tick
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_TIME_NS  = 100000;
    localparam int TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_CNT_W    = 12;

    // configuration record layout
    localparam int NUM_SLOTS    = 8;
    localparam int CFG_BYTES    = 12;
    localparam int POLL_DWELL   = 8;
    localparam int POLL_FIRST   = 9;
    localparam int POLL_TXN_CAP = 10;
    localparam int POLL_SPARE   = 11;

    // slot type codes
    localparam logic [7:0] SLOT_EMPTY   = 8'h00;
    localparam logic [7:0] SLOT_CASCADE = 8'h01;
    localparam logic [7:0] SLOT_MINI    = 8'h02;
    localparam logic [7:0] SLOT_HOST    = 8'h80;

    // reset values of the polling parameters
    localparam logic [7:0] DWELL_DEFAULT = 8'hb4;
    localparam logic [7:0] FIRST_DEFAULT = 8'h10;
    localparam logic [7:0] TXN_DEFAULT   = 8'h20;
    localparam logic [7:0] SPARE_DEFAULT = 8'h00;

    localparam logic [CFG_BYTES-1:0][7:0] CFG_DEFAULT =
        {SPARE_DEFAULT, TXN_DEFAULT, FIRST_DEFAULT, DWELL_DEFAULT, {NUM_SLOTS{SLOT_CASCADE}}};

    // register map, byte addresses
    localparam logic [7:0] REG_SLOT_BASE = 8'h00;
    localparam logic [7:0] REG_POLL_BASE = 8'h20;
    localparam logic [7:0] REG_CTRL      = 8'h30;
    localparam logic [7:0] REG_STATUS    = 8'h34;
    localparam int         CTRL_COMMIT   = 0;

    // status word fields
    localparam int ST_SLOT_LSB  = 0;
    localparam int ST_ENABLED   = 3;
    localparam int ST_GRANTED   = 4;
    localparam int ST_SERVING   = 5;
    localparam int ST_TXN_LSB   = 8;
    localparam int ST_TICK_LSB  = 16;

    // pins passing the synchroniser: eight slot requests, master flag, selector
    localparam int SYNC_W = 10;

    typedef enum logic [2:0] {
        KIND_EMPTY,
        KIND_CASCADE,
        KIND_MINI,
        KIND_HOST,
        KIND_INVALID
    } kind_t;

    typedef enum logic [1:0] {
        ARB_IDLE,
        ARB_SEEK,
        ARB_WAIT,
        ARB_SERVE
    } arb_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic [CFG_BYTES-1:0][7:0] shadow;
        logic [CFG_BYTES-1:0][7:0] record;
        arb_state_t                state;
        logic [2:0]                slot;
        logic [7:0]                ticks;
        logic [7:0]                txns;
        logic [NUM_SLOTS-1:0]      grant;
        kind_t                     kind;
        logic                      enabled;
        wb_rsp_t                   rsp;
    } arb_regs_t;

    function automatic kind_t decode_kind(input logic [7:0] code);
        case (code)
            SLOT_EMPTY:   decode_kind = KIND_EMPTY;
            SLOT_CASCADE: decode_kind = KIND_CASCADE;
            SLOT_MINI:    decode_kind = KIND_MINI;
            SLOT_HOST:    decode_kind = KIND_HOST;
            default:      decode_kind = KIND_INVALID;
        endcase
    endfunction

endpackage

/* File: testbench/host_slot_poll_arbiter_bench.sv */
// self-checking bench for the slot polling arbiter
`timescale 1ns/1ps
module host_slot_poll_arbiter_bench;
    import slot_poll_pkg::*;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    wb_req_t     wb_req = '0;
    wb_rsp_t     wb_rsp;
    logic [7:0]  req;
    logic        txn_done;
    logic        master = 1'b1;
    logic        switch = 1'b0;
    logic [7:0]  present = 8'h29;
    logic [7:0]  slow = 8'h20;
    logic [7:0]  grant;
    kind_t       kind;
    logic        active;
    logic [31:0] rd;
    int          fails = 0;
    int          check_count = 0;
    int          cycles = 0;
    logic [7:0]  dflt [12] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'hb4, 8'h10, 8'h20, 8'h00};
    logic [7:0]  cfg [12] = '{8'h80, 8'h00, 8'h02, 8'h05, 8'h00, 8'h01, 8'h00, 8'h00, 8'h02, 8'h01, 8'h03, 8'hff};
    int          exp_slot [4] = '{0, 2, 5, 0};
    kind_t       exp_kind [4] = '{KIND_HOST, KIND_MINI, KIND_CASCADE, KIND_HOST};
    int          min_len [4] = '{0, 0, 1990, 0};
    int          max_len [4] = '{200, 2010, 4010, 200};
    int          exp_tx [4] = '{3, 0, 0, 3};
    int          s;
    int          len;
    int          tx;
    kind_t       k;

    always #25 clk = ~clk;

    host_slot_poll_arbiter u_host_slot_poll_arbiter (.clk, .sys_rst, .wb_req, .wb_rsp, .slot_req_pin(req),
        .master_mux_pin(master), .switch_right_pin(switch), .txn_done, .slot_grant(grant), .slot_kind(kind),
        .arb_active(active));
    slot_hosts u_slot_hosts (.clk, .slot_grant(grant), .present, .slow, .slot_req_pin(req), .txn_done);

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // holds the request until ack is sampled, then releases for at least a cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        int n;
        n = 0;
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: {24'h0, dat}};
        do begin
            @(posedge clk);
            n++;
        // no local limit: a missing ack is left to the cycle ceiling
        end while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat;
        wb_req <= '0;
        check(32'(n), 32'h2, "bus answer");
    endtask

    task automatic rchk(input logic [7:0] adr, input logic [7:0] exp);
        wb(1'b0, adr, 8'h00);
        check(rd, {24'h0, exp}, "register read");
    endtask

    task automatic visit(output int slot, output int n, output int cnt, output kind_t kd);
        int w;
        w = 0;
        slot = -1;
        n = 0;
        cnt = 0;
        while (grant === 8'h00 && w < 5000) begin
            @(posedge clk);
            w++;
        end
        kd = kind;
        for (int i = 0; i < 8; i++) if (grant[i] === 1'b1) slot = i;
        while (grant !== 8'h00 && n < 9000) begin
            if (txn_done) cnt++;
            @(posedge clk);
            n++;
        end
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 12; i++) rchk(8'(i * 4), dflt[i]);
        wb(1'b1, 8'h38, 8'h5a);
        rchk(8'h38, 8'h00);
        for (int i = 0; i < 12; i++) wb(1'b1, 8'(i * 4), cfg[i]);
        wb(1'b1, 8'h30, 8'h01);
        rchk(8'h30, 8'h00);
        for (int i = 0; i < 12; i++) rchk(8'(i * 4), cfg[i]);
        // status before polling: pointer at the last slot, nothing enabled, granted or counted
        wb(1'b0, 8'h34, 8'h00);
        check(rd, 32'h7, "status word before polling");
        // shadow edit without commit must leave slot 0 in the live rotation
        wb(1'b1, 8'h00, 8'h00);
        rchk(8'h00, 8'h00);
        check({24'h0, grant}, 32'h0, "grant with selector left");
        check({31'h0, active}, 32'h0, "active with selector left");
        switch <= 1'b1;
        for (int v = 0; v < 4; v++) begin
            visit(s, len, tx, k);
            check(32'(s), 32'(exp_slot[v]), "visit order");
            check(32'(k), 32'(exp_kind[v]), "slot kind");
            check(32'(tx), 32'(exp_tx[v]), "transactions per visit");
            check(32'(len >= min_len[v]), 32'h1, "visit too short");
            check(32'(len <= max_len[v]), 32'h1, "visit too long");
        end
        // selector still right but this is no longer the master mux
        master <= 1'b0;
        repeat (10) @(posedge clk);
        check({31'h0, active}, 32'h0, "active with master flag low");
        check({24'h0, grant}, 32'h0, "grant with master flag low");
        master <= 1'b1;
        switch <= 1'b0;
        repeat (10) @(posedge clk);
        check({31'h0, active}, 32'h0, "active after selector off");
        check({24'h0, grant}, 32'h0, "grant after selector off");
        end_of_test();
    end
endmodule // host_slot_poll_arbiter_bench

/* File: testbench/slot_hosts.sv */
// behavioural hosts on the slots plus the drive completion pulse
`timescale 1ns/1ps
module slot_hosts (
    input  wire logic       clk,          // clock
    input  wire logic [7:0] slot_grant,   // slot linked to drive
    input  wire logic [7:0] present,      // hosts that keep requesting
    input  wire logic [7:0] slow,         // hosts with long transactions
    output logic      [7:0] slot_req_pin, // request levels
    output logic            txn_done      // one transaction finished
);
    int age = 0;
    initial slot_req_pin = 8'h00;
    initial txn_done = 1'b0;
    always @(posedge clk) begin
        slot_req_pin <= present;
        txn_done <= 1'b0;
        // age restarts per visit so a slow host never finishes inside a visit shorter than 5000 cycles
        if ((slot_grant & present) == 8'h00) begin
            age <= 0;
        end else begin
            age <= age + 1;
            if (age >= 8 && age % ((|(slot_grant & slow)) ? 5000 : 8) == 0) begin
                txn_done <= 1'b1;
            end
        end
    end
endmodule // slot_hosts

/* File: testbench/slot_poll_arbiter_asserts.sv */
// port checker for the slot polling arbiter
`timescale 1ns/1ps
module slot_poll_arbiter_asserts
    import slot_poll_pkg::*;
(
    input wire logic       clk,              // clock
    input wire logic       sys_rst,          // reset
    input wire wb_req_t    wb_req,           // bus request
    input wire wb_rsp_t    wb_rsp,           // bus answer
    input wire logic [7:0] slot_req_pin,     // slot requests
    input wire logic       master_mux_pin,   // master flag
    input wire logic       switch_right_pin, // selector
    input wire logic       txn_done,         // drive done
    input wire logic [7:0] slot_grant,       // granted slot
    input wire kind_t      slot_kind,        // granted kind
    input wire logic       arb_active        // polling on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_take;
        wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    endsequence
    sequence s_off2;
        !arb_active ##1 !arb_active;
    endsequence
    ack_answer_a: assert property (s_take |=> wb_rsp.ack)
        else $error("no ack after request");
    ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack longer than one cycle");
    grant_onehot_a: assert property ($onehot0(slot_grant))
        else $error("more than one slot granted");
    grant_gap_a: assert property (($changed(slot_grant) && |slot_grant) |-> $past(slot_grant) == 8'h00)
        else $error("grant moved without idle cycle");
    kind_usable_a: assert property (|slot_grant |-> slot_kind inside {KIND_CASCADE, KIND_MINI, KIND_HOST})
        else $error("unusable slot granted");
    idle_grant_a: assert property (s_off2 |-> slot_grant == 8'h00)
        else $error("grant while polling off");
    mode_on_a: assert property ((master_mux_pin && switch_right_pin) [*7] |-> arb_active)
        else $error("polling not enabled");
    mode_off_a: assert property ((!switch_right_pin) [*7] |-> !arb_active)
        else $error("polling enabled with selector left");
    master_off_a: assert property ((!master_mux_pin) [*7] |-> !arb_active)
        else $error("polling enabled without master flag");
endmodule // slot_poll_arbiter_asserts

bind host_slot_poll_arbiter slot_poll_arbiter_asserts u_slot_poll_arbiter_asserts (.clk, .sys_rst, .wb_req,
    .wb_rsp, .slot_req_pin, .master_mux_pin, .switch_right_pin, .txn_done, .slot_grant, .slot_kind, .arb_active);
